// ==== brc_pkg.sv ====
// Constants, register map and carrier types of the regulator control block.
// Assumes a 250 MHz system clock and a Wishbone bus with 32-bit data.
package brc_pkg;
	// ==========================================================
	// Clock and timing.
	localparam int CLK_PS = 4000;
	localparam int EN_DELAY_US = 5000;
	localparam int EN_DELAY_CYC = EN_DELAY_US * (1000000 / CLK_PS);
	localparam int RETRY_US = 1700;
	localparam int RETRY_CYC = RETRY_US * (1000000 / CLK_PS);
	localparam int OVP_FILT_NS = 1000;
	localparam int OVP_FILT_CYC = (OVP_FILT_NS * 1000 + CLK_PS - 1) / CLK_PS;
	// Fastest rising slew, and the output step it has to pace.
	localparam int SLEW_MAX_UV_PER_US = 64000;
	localparam int STEP_UV = 6250;
	localparam int STEP_PS = STEP_UV * 1000 / (SLEW_MAX_UV_PER_US / 1000);
	localparam int STEP_CYC = (STEP_PS + CLK_PS - 1) / CLK_PS;
	localparam int VOUT_BASE_UV = 350000;
	localparam logic [2:0] SS_SLEW = 3'h3;
	localparam logic [4:0] ILIM_RUN = 5'h10;
	// ==========================================================
	// Register indices; byte address is four times the index.
	localparam logic [2:0] IDX_VLO = 3'h0;
	localparam logic [2:0] IDX_VHI = 3'h1;
	localparam logic [2:0] IDX_CTRL = 3'h2;
	localparam logic [2:0] IDX_MON = 3'h5;
	localparam int EN_BIT = 7;
	localparam int DIS_BIT = 7;
	localparam int SLEW_LSB = 4;
	localparam int MODE_LO_BIT = 0;
	localparam int MODE_HI_BIT = 1;
	localparam logic [7:0] VLO_RST = 8'h88;
	localparam logic [7:0] VHI_RST = 8'h98;
	localparam logic [7:0] CTRL_RST = 8'h82;
	// ==========================================================
	// Carriers.
	typedef struct packed {
		logic at_tgt;
		logic cyc;
		logic ilim;
		logic otp;
		logic ovp;
		logic uvlo;
		logic voltage_select_pin;
		logic en;
	} brc_pins_t;
	typedef struct packed {
		logic on;
		logic hiz;
		logic hs_off;
		logic sync_rect;
		logic pfm;
		logic dischg;
	} brc_drive_t;
endpackage

// ==== brc_ctrl.sv ====
// Digital control of a programmable step-down regulator.
// Assumes asynchronous pin and comparator inputs and a classic Wishbone master.
// Functional notes
// R01: Enable pin low forces shutdown regardless of select pin and software enables.
// R02: Pin high follows selected register enable; low select auto mode, high forced PWM.
// R03: Registers keep contents and stay accessible while the enable pin is low.
// R04: Power-on reset returns every register, both voltage registers included, to default.
// R05: Both software enable bits reset high so the regulator starts either way.
// R06: Discharge bit set and pin or selected enable low connects output discharge.
// R07: Enable with software enable starts soft-start; delayed variant waits 5 ms first.
// R08: Soft-start ramps the reference slowly with synchronous rectification inhibited.
// R09: Current threshold reached turns the high-side switch off for that cycle.
// R10: Sixteen consecutive limited cycles shut down tri-stated, wait 1700 us, retry.
// R11: Limit counter clears on an unlimited cycle and on shutdown or restart.
// R12: Target voltage is 0.35 V plus code times 6.25 mV.
// R13: Select pin low picks the low register, high picks the high register.
// R14: Rising transitions paced by three-bit slew code, 64 mV/us halving per code.
// R15: Falling transitions stop switching until the output reaches the new target.
// R16: PFM enable comes from control mode bits combined with the select pin.
// R17: Under-voltage indication holds the converter inactive while the pin is high.
// R18: Filtered over-voltage indication stops switching.
// R19: Thermal indication disables switching until it clears.
// R20: Host may reprogram voltage, mode, slew and enable at any time.
// R21: Voltage register bit 7 is software enable, bits 6:0 the voltage code.
`timescale 1ns/10ps
`default_nettype none
module brc_ctrl #(
	parameter int EN_DELAY_CYC = brc_pkg::EN_DELAY_CYC,
	parameter int RETRY_CYC = brc_pkg::RETRY_CYC,
	parameter bit DELAYED_START = 1'b0
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire brc_pkg::brc_pins_t pins_i,
	output brc_pkg::brc_drive_t drive_o,
	output logic [6:0] ref_code_o,
	output logic [20:0] ref_uv_o
);
	typedef enum logic [2:0] {
		ST_OFF, ST_DELAY, ST_SOFT, ST_REG, ST_FALL, ST_RETRY
	} brc_state_t;

	// ==========================================================
	// Input synchronisers.
	brc_pkg::brc_pins_t sync1, pin;
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_sync
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					sync1[g] <= 1'b0;
					pin[g] <= 1'b0;
				end else begin
					sync1[g] <= pins_i[g];
					pin[g] <= sync1[g];
				end
			end
		end
	endgenerate

	// ==========================================================
	// Registers.
	logic [7:0] vreg_lo, vreg_hi, ctrl;
	logic wr;
	brc_state_t state, next_state;
	logic ovp_f, cl_hit;
	logic [6:0] ref_code;
	assign wr = cyc_i & stb_i & we_i & ack_o & sel_i[0];

	// Writes land at the edge that sees ack, whatever the pins show.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			vreg_lo <= brc_pkg::VLO_RST; // R04 R05
			vreg_hi <= brc_pkg::VHI_RST; // R04 R05
			ctrl <= brc_pkg::CTRL_RST; // R04
		end else if (wr) begin
			case (adr_i[4:2]) // R03 R20
				brc_pkg::IDX_VLO: vreg_lo <= dat_i[7:0];
				brc_pkg::IDX_VHI: vreg_hi <= dat_i[7:0];
				brc_pkg::IDX_CTRL: ctrl <= dat_i[7:0];
				default: ;
			endcase
		end
	end

	logic regulating, fault;
	logic [7:0] monitor;
	assign monitor = {regulating, ovp_f, pin.otp, pin.uvlo,
		state == ST_RETRY, state == ST_FALL, 1'b0, regulating};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0;
		end else begin
			ack_o <= cyc_i & stb_i & ~ack_o;
			dat_o <= 32'h0;
			if (cyc_i & stb_i & ~ack_o & ~we_i) begin
				case (adr_i[4:2])
					brc_pkg::IDX_VLO: dat_o <= {24'h0, vreg_lo};
					brc_pkg::IDX_VHI: dat_o <= {24'h0, vreg_hi};
					brc_pkg::IDX_CTRL: dat_o <= {24'h0, ctrl};
					brc_pkg::IDX_MON: dat_o <= {24'h0, monitor};
					default: dat_o <= 32'h0;
				endcase
			end
		end
	end

	// ==========================================================
	// Selection and enables.
	logic [7:0] voltage_select_pin_reg;
	logic sel_en, run_req, forced, switching;
	logic [6:0] target;
	logic [2:0] slew;
	assign voltage_select_pin_reg = pin.voltage_select_pin ? vreg_hi : vreg_lo; // R13
	assign sel_en = voltage_select_pin_reg[brc_pkg::EN_BIT]; // R21
	assign target = voltage_select_pin_reg[6:0]; // R21
	assign run_req = pin.en & sel_en; // R01 R02
	assign forced = pin.voltage_select_pin ? ctrl[brc_pkg::MODE_HI_BIT] : ctrl[brc_pkg::MODE_LO_BIT]; // R16
	assign slew = ctrl[brc_pkg::SLEW_LSB +: 3];
	assign fault = pin.uvlo | ovp_f | pin.otp; // R17 R18 R19
	assign switching = (state == ST_SOFT) | (state == ST_REG);
	assign regulating = (state == ST_REG) & ~fault;

	// ==========================================================
	// Over-voltage filter: a spike shorter than the window is ignored.
	logic [8:0] ovp_cnt;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ovp_cnt <= 9'h0;
			ovp_f <= 1'b0;
		end else if (!pin.ovp) begin
			ovp_cnt <= 9'h0;
			ovp_f <= 1'b0;
		end else if (ovp_cnt == 9'(brc_pkg::OVP_FILT_CYC - 1)) begin
			ovp_f <= 1'b1; // R18
		end else begin
			ovp_cnt <= ovp_cnt + 9'h1;
		end
	end

	// ==========================================================
	// Current limit per switching cycle.
	logic cyc_d, cyc_rise, ilim_trip;
	logic [4:0] ilim_cnt;
	assign cyc_rise = pin.cyc & ~cyc_d;
	assign ilim_trip = cyc_rise & cl_hit & (ilim_cnt == brc_pkg::ILIM_RUN - 5'h1);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cyc_d <= 1'b0;
			cl_hit <= 1'b0;
			ilim_cnt <= 5'h0;
		end else begin
			cyc_d <= pin.cyc;
			if (!switching) begin
				cl_hit <= 1'b0;
				ilim_cnt <= 5'h0; // R11
			end else if (cyc_rise) begin
				cl_hit <= pin.ilim;
				ilim_cnt <= cl_hit ? ilim_cnt + 5'h1 : 5'h0; // R10 R11
			end else if (pin.ilim) begin
				cl_hit <= 1'b1; // R09
			end
		end
	end

	// ==========================================================
	// Sequencer.
	logic [31:0] timer;
	logic ramp_done;
	assign ramp_done = ref_code >= target;
	always_comb begin
		next_state = state;
		case (state)
			ST_OFF: begin
				if (run_req && !fault) begin
					next_state = DELAYED_START ? ST_DELAY : ST_SOFT; // R07
				end
			end
			ST_DELAY: begin
				if (timer == 32'(EN_DELAY_CYC - 1)) begin
					next_state = ST_SOFT; // R07
				end
			end
			ST_SOFT: begin
				if (ramp_done) begin
					next_state = ST_REG;
				end
			end
			ST_REG: begin
				if (ref_code > target) begin
					next_state = ST_FALL; // R15
				end
			end
			ST_FALL: begin
				if (pin.at_tgt) begin
					next_state = ST_REG; // R15
				end
			end
			ST_RETRY: begin
				if (timer == 32'(RETRY_CYC - 1)) begin
					next_state = ST_SOFT; // R10
				end
			end
			default: next_state = ST_OFF;
		endcase
		if (ilim_trip) begin
			next_state = ST_RETRY; // R10
		end
		if (!run_req || fault) begin
			next_state = ST_OFF; // R01 R17 R18 R19
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= ST_OFF;
			timer <= 32'h0;
		end else begin
			state <= next_state;
			timer <= (next_state == state) ? timer + 32'h1 : 32'h0;
		end
	end

	// ==========================================================
	// Reference ramp; soft-start uses a fixed slow rate.
	logic [11:0] step_cnt, step_len;
	assign step_len = 12'(brc_pkg::STEP_CYC) << (state == ST_SOFT ? brc_pkg::SS_SLEW : slew);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ref_code <= 7'h0;
			step_cnt <= 12'h0;
		end else if (!switching && state != ST_FALL) begin
			ref_code <= 7'h0; // R08
			step_cnt <= 12'h0;
		end else if (ref_code > target) begin
			ref_code <= target; // R15
			step_cnt <= 12'h0;
		end else if (ref_code < target) begin
			if (step_cnt >= step_len - 12'h1) begin
				step_cnt <= 12'h0;
				ref_code <= ref_code + 7'h1; // R08 R14
			end else begin
				step_cnt <= step_cnt + 12'h1;
			end
		end else begin
			step_cnt <= 12'h0;
		end
	end

	// ==========================================================
	// Registered outputs.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			drive_o <= '0;
			ref_code_o <= 7'h0;
			ref_uv_o <= 21'(brc_pkg::VOUT_BASE_UV);
		end else begin
			drive_o.on <= switching | (state == ST_FALL);
			drive_o.hiz <= ~switching; // R10 R15
			drive_o.hs_off <= switching & (pin.ilim | cl_hit); // R09
			drive_o.sync_rect <= state == ST_REG; // R08
			drive_o.pfm <= (state == ST_REG) & ~forced; // R02 R16
			drive_o.dischg <= ctrl[brc_pkg::DIS_BIT] & ~run_req; // R06
			ref_code_o <= ref_code;
			ref_uv_o <= 21'(brc_pkg::VOUT_BASE_UV) + 21'(ref_code) * 21'(brc_pkg::STEP_UV); // R12
		end
	end

	// ==========================================================
	// Checks.
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_trip;
		ilim_trip && run_req && !fault;
	endsequence
	sequence s_wait;
		(state == ST_RETRY && drive_o.hiz) [*8];
	endsequence
	pin_off_a: assert property (!pin.en |-> ##2 !drive_o.on) // R01
		else $error("converter on with enable low");
	auto_pfm_a: assert property (state == ST_REG && !forced && !fault && run_req
		|=> drive_o.pfm) // R02
		else $error("pfm not enabled in auto mode");
	por_vals_a: assert property ($past(rst_i) |-> vreg_lo[7] && vreg_hi[7]
		&& ctrl == brc_pkg::CTRL_RST) // R04
		else $error("reset values wrong");
	dischg_on_a: assert property (ctrl[7] && !pin.en |=> drive_o.dischg) // R06
		else $error("discharge not applied");
	soft_rect_a: assert property (state == ST_SOFT |=> !drive_o.sync_rect) // R08
		else $error("rectifier active in soft-start");
	hs_cut_a: assert property (switching && pin.ilim |=> drive_o.hs_off) // R09
		else $error("high side not cut");
	retry_wait_a: assert property (s_trip |=> ##1 s_wait) // R10
		else $error("retry wait broken");
	ref_volt_a: assert property (ref_uv_o == 21'(brc_pkg::VOUT_BASE_UV)
		+ 21'($past(ref_code)) * 21'(brc_pkg::STEP_UV)) // R12
		else $error("voltage mapping wrong");
	fall_stop_a: assert property (state == ST_FALL |=> drive_o.hiz) // R15
		else $error("switching during fall");
	ovp_filt_a: assert property ($rose(pin.ovp) |-> !ovp_f [*8]) // R18
		else $error("over-voltage not filtered");
	hot_stop_a: assert property (pin.otp |=> state == ST_OFF) // R19
		else $error("thermal did not stop");
endmodule
`default_nettype wire

// ==== brc_host_model.sv ====
// Host that programs the regulator control block over classic Wishbone.
// Assumes a slave with a registered one-cycle ack on clk_i.
`timescale 1ns/10ps
`default_nettype none
module brc_host_model (
	input wire logic clk_i,
	input wire logic ack_i,
	input wire logic [31:0] dat_i,
	output logic cyc_o,
	output logic stb_o,
	output logic we_o,
	output logic [7:0] adr_o,
	output logic [3:0] sel_o,
	output logic [31:0] dat_o
);
	logic tmo = 1'b0;
	initial begin
		cyc_o = 1'b0;
		stb_o = 1'b0;
		we_o = 1'b0;
		adr_o = 8'h00;
		sel_o = 4'h0;
		dat_o = 32'h0;
	end
	// ==========================================================
	// One access; the request stands until ack is sampled high or 64 cycles pass without it.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
			output logic [7:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o <= w;
		adr_o <= a;
		sel_o <= 4'h1;
		dat_o <= {24'h0, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_i !== 1'b1 && n < 64);
		q = dat_i[7:0];
		tmo = tmo | (n >= 64);
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		// Released data is inverted so a stale value never looks valid.
		dat_o <= ~dat_o;
	endtask
endmodule
`default_nettype wire

// ==== buck_regulator_control_logic_bench.sv ====
// Self-checking bench of the regulator control block.
// Assumes the host model for bus access; pins are driven here.
`timescale 1ns/10ps
`default_nettype none
module buck_regulator_control_logic_bench;
	logic clk_i, rst_i, cyc, stb, we, ack;
	logic [7:0] adr, q;
	logic [3:0] sel;
	logic [31:0] wdat, rdat;
	logic [6:0] code;
	logic [20:0] uv;
	brc_pkg::brc_pins_t p;
	brc_pkg::brc_drive_t d, d2;
	int miscompares = 0;
	int checked = 0;
	int n;
	// Columns: en, voltage_select_pin, low enable, high enable, on, discharge.
	logic [5:0] rows [5] = '{6'b011101, 6'b100101, 6'b101010, 6'b111001, 6'b110110};
	brc_ctrl #(.EN_DELAY_CYC(50), .RETRY_CYC(40), .DELAYED_START(1'b0)) dut_u (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
		.pins_i(p), .drive_o(d), .ref_code_o(code), .ref_uv_o(uv));
	brc_host_model host_u (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc),
		.stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
	// Second copy with the start delay; its bus stays idle so both enables keep reset values.
	brc_ctrl #(.EN_DELAY_CYC(50), .RETRY_CYC(40), .DELAYED_START(1'b1)) dut_dly_u (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(1'b0), .stb_i(1'b0), .we_i(1'b0),
		.adr_i(8'h00), .sel_i(4'h0), .dat_i(32'h0), .dat_o(), .ack_o(),
		.pins_i(p), .drive_o(d2), .ref_code_o(), .ref_uv_o());
	// ==========================================================
	// Checks and bus helpers.
	task automatic chk_val(input logic [20:0] got, input logic [20:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t value %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t flag %b expected %b", $time, got, exp);
		end
	endtask
	task automatic end_sim;
		if (host_u.tmo === 1'b1) miscompares++;
		$display("checked=%0d miscompares=%0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		host_u.xfer(1'b1, a, v, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		host_u.xfer(1'b0, a, 8'h00, q);
		chk_val({13'h0, q}, {13'h0, e});
	endtask
	task automatic wait_code(input logic [6:0] c);
		n = 0;
		while (code !== c && n < 9000) begin
			@(posedge clk_i);
			n++;
		end
		if (n == 9000) begin
			miscompares++;
			end_sim();
		end
	endtask
	// ==========================================================
	// Clocks, watchdog and main sequence.
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	// The switching clock is unrelated in phase to clk_i.
	initial begin
		#1.3;
		forever #62.5 p.cyc = ~p.cyc;
	end
	initial begin
		#200000;
		miscompares++;
		end_sim();
	end
	initial begin
		rst_i = 1'b1;
		p = '0;
		repeat (20) @(posedge clk_i);
		chk_val(uv, 21'd350000);
		chk_bit(d.on, 1'b0);
		rst_i <= 1'b0;
		rd(8'h00, brc_pkg::VLO_RST);
		rd(8'h04, brc_pkg::VHI_RST);
		rd(8'h08, brc_pkg::CTRL_RST);
		wr(8'h0c, 8'h5a);
		rd(8'h0c, 8'h00);
		wr(8'h00, 8'h85);
		rd(8'h00, 8'h85);
		for (int i = 0; i < 5; i++) begin
			wr(8'h00, {rows[i][3], 7'h08});
			wr(8'h04, {rows[i][2], 7'h18});
			p.en <= rows[i][5];
			p.voltage_select_pin <= rows[i][4];
			repeat (8) @(posedge clk_i);
			chk_bit(d.on, rows[i][1]);
			chk_bit(d.dischg, rows[i][0]);
		end
		chk_bit(d.sync_rect, 1'b0);
		wait_code(7'h18);
		chk_val(uv, 21'd500000);
		rd(8'h14, 8'h81);
		wr(8'h00, 8'h88);
		p.voltage_select_pin <= 1'b0;
		repeat (6) @(posedge clk_i);
		chk_val({14'h0, code}, 21'h08);
		chk_bit(d.hiz, 1'b1);
		p.at_tgt <= 1'b1;
		repeat (6) @(posedge clk_i);
		chk_bit(d.hiz, 1'b0);
		chk_bit(d.pfm, 1'b1);
		wr(8'h08, 8'h83);
		repeat (3) @(posedge clk_i);
		chk_bit(d.pfm, 1'b0);
		p.at_tgt <= 1'b0;
		p.voltage_select_pin <= 1'b1;
		wait_code(7'h18);
		chk_bit(n >= 370 && n <= 430, 1'b1);
		chk_bit(d.pfm, 1'b0);
		p.otp <= 1'b1;
		repeat (5) @(posedge clk_i);
		chk_bit(d.on, 1'b0);
		p.otp <= 1'b0;
		repeat (8) @(posedge clk_i);
		chk_bit(d.on, 1'b1);
		p.ovp <= 1'b1;
		repeat (100) @(posedge clk_i);
		chk_bit(d.on, 1'b1);
		repeat (200) @(posedge clk_i);
		chk_bit(d.on, 1'b0);
		p.ovp <= 1'b0;
		p.uvlo <= 1'b1;
		repeat (5) @(posedge clk_i);
		chk_bit(d.on, 1'b0);
		p.uvlo <= 1'b0;
		repeat (8) @(posedge clk_i);
		p.ilim <= 1'b1;
		repeat (4) @(posedge clk_i);
		chk_bit(d.hs_off, 1'b1);
		n = 0;
		while (d.hiz !== 1'b1 && n < 2000) begin
			@(posedge clk_i);
			n++;
		end
		chk_bit(n >= 440 && n < 2000, 1'b1);
		p.ilim <= 1'b0;
		repeat (30) @(posedge clk_i);
		chk_bit(d.hiz, 1'b1);
		repeat (30) @(posedge clk_i);
		chk_bit(d.hiz, 1'b0);
		chk_bit(d.on, 1'b1);
		wr(8'h08, 8'h00);
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(8'h08, brc_pkg::CTRL_RST);
		repeat (10) @(posedge clk_i);
		chk_bit(d.on, 1'b1);
		chk_bit(d2.on, 1'b0);
		repeat (50) @(posedge clk_i);
		chk_bit(d2.on, 1'b1);
		end_sim();
	end
endmodule
`default_nettype wire
